/* hdl/gsp_learn.sv */
// Stop position learning sequencer: automatic, manual and mixed modes
`timescale 1ns/10ps
module gsp_learn #(
	parameter gsp_pkg::gsp_cnt_t MAN_CYC   = gsp_pkg::CYC_MAN,
	parameter gsp_pkg::gsp_cnt_t AUTO_CYC  = gsp_pkg::CYC_AUTO,
	parameter gsp_pkg::gsp_cnt_t LIT_CYC   = gsp_pkg::CYC_LIT,
	parameter gsp_pkg::gsp_cnt_t STORE_CYC = gsp_pkg::CYC_STORE,
	parameter gsp_pkg::gsp_cnt_t IDLE_CYC  = gsp_pkg::CYC_IDLE,
	parameter gsp_pkg::gsp_cnt_t BRIEF_CYC = gsp_pkg::CYC_BRIEF,
	parameter gsp_pkg::gsp_cnt_t SLOW_CYC  = gsp_pkg::CYC_SLOW,
	parameter gsp_pkg::gsp_cnt_t FAST_CYC  = gsp_pkg::CYC_FAST
) (
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic               clkEn,
	input  wire gsp_pkg::gsp_pins_s pinsAsync,
	input  wire gsp_pkg::gsp_pos_t  m1Pos,
	input  wire gsp_pkg::gsp_pos_t  m2Pos,
	input  wire logic               devLearnPending,
	output gsp_pkg::gsp_ind_t       posInd,
	output gsp_pkg::gsp_motor_s     motorCmd,
	output gsp_pkg::gsp_tbl_t       posTable,
	output logic                    leafOneGo,
	output logic                    leafTwoGo,
	output logic                    m1AtOpen,
	output logic                    m2AtOpen,
	output logic                    learnBusy,
	output logic                    learnFailed,
	output logic                    autoLearned
);
	import gsp_pkg::*;
	gsp_learn_s r;
	gsp_learn_s n;
	gsp_pins_s  p;
	logic       slowOn;
	logic       fastOn;
	logic       autoRun;
	logic       trip;
	logic       dirBtn;
	logic       m1Done;
	logic       m2Done;
	logic       closedBoth;
	gsp_pos_t   selPos;
	gsp_pos_t   saPos;

	// Pins are asynchronous to the unit clock
	gsp_sync uSync (
		.clock     (clock),
		.arst_n    (arst_n),
		.clkEn     (clkEn),
		.pinsAsync (pinsAsync),
		.pinsSync  (p)
	);

	gsp_blink #(
		.SLOW_CYC (SLOW_CYC),
		.FAST_CYC (FAST_CYC)
	) uBlink (
		.clock  (clock),
		.arst_n (arst_n),
		.clkEn  (clkEn),
		.slowOn (slowOn),
		.fastOn (fastOn)
	);

	// Shared terms; stop sense while opening only counts once off the closed stop
	assign autoRun    = r.st inside {ST_ACL1, ST_ACL2, ST_AOPN, ST_AFCL};
	assign trip       = p.photo || p.stopIn;
	assign dirBtn     = p.open || p.close;
	// Done once the open stop is latched apart from the closed one; a live stall flag
	// drops as soon as the motor halts, and two leaves arriving apart would never agree
	assign m1Done     = r.tbl[IDX_OP1] != r.tbl[IDX_CL1];
	assign m2Done     = r.tbl[IDX_OP2] != r.tbl[IDX_CL2];
	assign closedBoth = (m1Pos <= r.tbl[IDX_CL1]) && (m2Pos <= r.tbl[IDX_CL2]);
	assign selPos     = usesMotorTwo(r.sel) ? m2Pos : m1Pos;
	assign saPos      = r.tbl[IDX_SA2];

	// Next-state logic of the whole sequencer
	always_comb begin
		n = r;
		n.mot = '0;
		n.prev = p;
		n.leafOneGo = m2Pos > r.tbl[IDX_SA2];
		n.leafTwoGo = m1Pos < r.tbl[IDX_SC1];
		n.m1AtOpen = m1Pos >= r.tbl[IDX_A1];
		n.m2AtOpen = m2Pos >= r.tbl[IDX_A2];
		unique case (r.st)
			ST_IDLE: begin
				n.holdCnt = '0;
				// Device learning must come first; rerun allowed any time after
				if (p.close && p.confirm && !devLearnPending) begin
					n.st = ST_ARM;
					n.failFlag = 1'b0;
				end
			end
			ST_ARM: begin
				if (p.close && p.confirm) begin
					if (r.holdCnt >= AUTO_CYC - 1'b1) begin
						n.st = ST_ARMA;
					end else begin
						n.holdCnt = r.holdCnt + 1'b1;
					end
				end else if (r.holdCnt >= MAN_CYC) begin
					n.st = ST_MAN;
					n.sel = IDX_CL1;
					n.mixed = r.autoOk;
					n.idleCnt = '0;
					n.holdCnt = '0;
					n.btnCnt = '0;
				end else begin
					n.st = ST_IDLE;
				end
			end
			ST_ARMA: begin
				// Motors wait until the installer lets go
				if (!p.close && !p.confirm) begin
					n.st = ST_ACL1;
				end
			end
			ST_ACL1: begin
				n.mot.m1 = DRV_CLOSE_SLOW;
				if (p.m1Stop) begin
					n.mot.m1 = '0;
					n.tbl[IDX_CL1] = m1Pos;
					n.st = ST_ACL2;
				end
			end
			ST_ACL2: begin
				n.mot.m2 = DRV_CLOSE_SLOW;
				if (p.m2Stop) begin
					n.mot.m2 = '0;
					n.tbl[IDX_CL2] = m2Pos;
					// Open slots equal the closed ones until each open stop is found
					n.tbl[IDX_OP1] = r.tbl[IDX_CL1];
					n.tbl[IDX_OP2] = m2Pos;
					n.st = ST_AOPN;
				end
			end
			ST_AOPN: begin
				if (!m1Done) begin
					n.mot.m1 = DRV_OPEN_SLOW;
					if (p.m1Stop && m1Pos != r.tbl[IDX_CL1]) begin
						n.tbl[IDX_OP1] = m1Pos;
					end
				end
				if (!m2Done) begin
					n.mot.m2 = DRV_OPEN_SLOW;
					if (p.m2Stop && m2Pos != r.tbl[IDX_CL2]) begin
						n.tbl[IDX_OP2] = m2Pos;
					end
				end
				// Both at the open stops: derive offsets and halt points
				if (m1Done && m2Done) begin
					n.tbl[IDX_A1] = r.tbl[IDX_OP1];
					n.tbl[IDX_A2] = r.tbl[IDX_OP2];
					n.tbl[IDX_SA2] = offsetPt(r.tbl[IDX_CL2], r.tbl[IDX_OP2]);
					n.tbl[IDX_SC1] = offsetPt(r.tbl[IDX_CL1], r.tbl[IDX_OP1]);
					n.st = ST_AFCL;
				end
			end
			ST_AFCL: begin
				if (closedBoth) begin
					n.st = ST_IDLE;
					n.autoOk = 1'b1;
				end else begin
					n.mot.m1 = DRV_CLOSE_FAST;
					n.mot.m2 = DRV_CLOSE_FAST;
				end
			end
			ST_MAN: begin
				// Inactivity ends the session, table untouched
				if (dirBtn || p.confirm) begin
					n.idleCnt = '0;
				end else if (r.idleCnt >= IDLE_CYC - 1'b1) begin
					n.st = ST_IDLE;
				end else begin
					n.idleCnt = r.idleCnt + 1'b1;
				end
				// Short press steps selection; long press jogs the motor
				if (dirBtn && !p.confirm) begin
					if (r.btnCnt < BRIEF_CYC) begin
						n.btnCnt = r.btnCnt + 1'b1;
					end else if (usesMotorTwo(r.sel)) begin
						n.mot.m2 = p.open ? DRV_OPEN_SLOW : DRV_CLOSE_SLOW;
					end else begin
						n.mot.m1 = p.open ? DRV_OPEN_SLOW : DRV_CLOSE_SLOW;
					end
				end else begin
					n.btnCnt = '0;
					if (r.btnCnt != '0 && r.btnCnt < BRIEF_CYC) begin
						n.sel = r.prev.open ? r.sel + 1'b1 : r.sel - 1'b1;
					end
				end
				// Confirm held past the store time commits on release
				if (p.confirm) begin
					if (r.holdCnt < STORE_CYC) begin
						n.holdCnt = r.holdCnt + 1'b1;
					end
				end else begin
					n.holdCnt = '0;
					if (r.prev.confirm && r.holdCnt >= STORE_CYC) begin
						if (!(r.mixed && isStopPos(r.sel))) begin
							n.tbl[r.sel] = selPos;
						end
						n.sel = r.sel + 1'b1;
						if (r.sel == IDX_OP2) begin
							n.st = ST_IDLE;
						end
					end
				end
			end
			default: begin
				n = LEARN_RST;
			end
		endcase
		// Safety trips win over an installer halt
		if (autoRun && (trip || dirBtn)) begin
			n.st = ST_IDLE;
			n.mot = '0;
			n.failFlag = trip;
		end
		n.busy = n.st != ST_IDLE;
		// Indicators follow the state being entered
		n.ind = '0;
		unique case (n.st)
			ST_IDLE: begin
				if (n.failFlag) begin
					n.ind = slowOn ? IND_ONE : '0;
				end else if (devLearnPending) begin
					n.ind = slowOn ? IND_PEND : '0;
				end
			end
			ST_ARM: begin
				if (n.holdCnt >= MAN_CYC) begin
					n.ind = slowOn ? IND_ONE : '0;
				end
			end
			ST_MAN: begin
				if (p.confirm && n.holdCnt >= LIT_CYC) begin
					n.ind = indBit(n.sel);
				end else if (slowOn) begin
					n.ind = indBit(n.sel);
				end
			end
			default: begin
				n.ind = fastOn ? IND_AUTO : '0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			r <= LEARN_RST;
		end else if (clkEn) begin
			r <= n;
		end
	end

	// All outputs straight from the state register
	assign posInd      = r.ind;
	assign motorCmd    = r.mot;
	assign posTable    = r.tbl;
	assign leafOneGo   = r.leafOneGo;
	assign leafTwoGo   = r.leafTwoGo;
	assign m1AtOpen    = r.m1AtOpen;
	assign m2AtOpen    = r.m2AtOpen;
	assign learnBusy   = r.busy;
	assign learnFailed = r.failFlag;
	assign autoLearned = r.autoOk;

	// Checks on the sequencer
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	sequence sAutoRun;
		clkEn && autoRun;
	endsequence

	sequence sBackIdle;
		r.st == ST_IDLE && r.mot == '0;
	endsequence

	AST_ABORT_TRIP: assert property (
		sAutoRun ##0 trip |=> sBackIdle ##0 r.failFlag
	) else $error("Trip did not abort automatic learning");

	AST_HALT_BTN: assert property (
		sAutoRun ##0 (!trip && dirBtn) |=> sBackIdle ##0 !r.failFlag
	) else $error("Button did not halt automatic learning");

	AST_DONE_OFF: assert property (
		clkEn && r.st == ST_AFCL && closedBoth && !trip && !dirBtn
		|=> r.st == ST_IDLE && r.ind[3:2] == 2'h0 && r.autoOk
	) else $error("Indicators three and four not cleared on success");

	AST_ONE_IND: assert property (
		r.st == ST_MAN |-> $onehot0(r.ind) && (r.ind & ~indBit(r.sel)) == '0
	) else $error("Manual mode shows a wrong indicator");

	AST_STOP_LOCK: assert property (
		clkEn && r.st == ST_MAN && r.mixed && isStopPos(r.sel) |=> $stable(r.tbl)
	) else $error("Stop position changed in mixed mode");

	AST_CLOSE_FIRST: assert property (
		clkEn && r.st == ST_ACL1 && !p.m1Stop && !trip && !dirBtn
		|=> r.mot.m1 == DRV_CLOSE_SLOW && !r.mot.m2.run
	) else $error("First automatic move is not a slow close of motor one");

	AST_RELEASE: assert property (
		clkEn && r.st == ST_MAN && !dirBtn |=> !r.mot.m1.run && !r.mot.m2.run
	) else $error("Motor still runs after button release");

	AST_PENDING: assert property (
		clkEn && r.st == ST_IDLE && devLearnPending && !r.failFlag
		|=> r.st == ST_IDLE && r.ind[7:2] == '0 && r.ind[1] == r.ind[0]
	) else $error("Pending device learning not shown correctly");

	AST_OPEN_OFS: assert property (
		$past(clkEn) && $past(arst_n) |-> r.leafOneGo == ($past(m2Pos) > $past(saPos))
	) else $error("Opening offset release of leaf one is wrong");
endmodule : gsp_learn

/* include/gsp_pkg.sv */
// Constants and types for the gate stop position learning sequencer
package gsp_pkg;
	// Timebase
	localparam int unsigned CLK_HZ     = 10_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned T_MAN_S    = 3;
	localparam int unsigned T_AUTO_S   = 5;
	localparam int unsigned T_LIT_S    = 2;
	localparam int unsigned T_STORE_S  = 3;
	localparam int unsigned T_IDLE_S   = 10;
	localparam int unsigned T_BRIEF_MS = 500;
	localparam int unsigned T_SLOW_MS  = 250;
	localparam int unsigned T_FAST_MS  = 100;

	// Widths
	localparam int unsigned CNT_W = 28;
	localparam int unsigned POS_W = 16;
	localparam int unsigned NIND  = 8;
	localparam int unsigned IDX_W = 3;
	typedef logic [CNT_W-1:0]           gsp_cnt_t;
	typedef logic [POS_W-1:0]           gsp_pos_t;
	typedef logic [NIND-1:0]            gsp_ind_t;
	typedef logic [IDX_W-1:0]           gsp_idx_t;
	typedef logic [NIND-1:0][POS_W-1:0] gsp_tbl_t;

	// Cycle counts derived from the times above
	localparam gsp_cnt_t CYC_MAN   = CNT_W'(T_MAN_S * CLK_HZ);
	localparam gsp_cnt_t CYC_AUTO  = CNT_W'(T_AUTO_S * CLK_HZ);
	localparam gsp_cnt_t CYC_LIT   = CNT_W'(T_LIT_S * CLK_HZ);
	localparam gsp_cnt_t CYC_STORE = CNT_W'(T_STORE_S * CLK_HZ);
	localparam gsp_cnt_t CYC_IDLE  = CNT_W'(T_IDLE_S * CLK_HZ);
	localparam gsp_cnt_t CYC_BRIEF = CNT_W'(T_BRIEF_MS * CYC_PER_MS);
	localparam gsp_cnt_t CYC_SLOW  = CNT_W'(T_SLOW_MS * CYC_PER_MS);
	localparam gsp_cnt_t CYC_FAST  = CNT_W'(T_FAST_MS * CYC_PER_MS);

	// Position slots, one per indicator
	localparam gsp_idx_t IDX_CL1 = 3'h0;
	localparam gsp_idx_t IDX_CL2 = 3'h1;
	localparam gsp_idx_t IDX_SA2 = 3'h2;
	localparam gsp_idx_t IDX_A1  = 3'h3;
	localparam gsp_idx_t IDX_A2  = 3'h4;
	localparam gsp_idx_t IDX_SC1 = 3'h5;
	localparam gsp_idx_t IDX_OP1 = 3'h6;
	localparam gsp_idx_t IDX_OP2 = 3'h7;
	localparam gsp_ind_t MOTOR2_MASK = 8'h96;
	localparam gsp_ind_t STOP_MASK   = 8'hC3;
	localparam gsp_ind_t IND_ONE     = 8'h01;
	localparam gsp_ind_t IND_PEND    = 8'h03;
	localparam gsp_ind_t IND_AUTO    = 8'h0C;
	localparam int unsigned OFS_SHIFT = 2;

	typedef struct packed {
		logic open;
		logic close;
		logic confirm;
		logic photo;
		logic stopIn;
		logic m1Stop;
		logic m2Stop;
	} gsp_pins_s;

	typedef struct packed {
		logic run;
		logic dirOpen;
		logic fast;
	} gsp_drive_s;

	typedef struct packed {
		gsp_drive_s m1;
		gsp_drive_s m2;
	} gsp_motor_s;

	localparam gsp_drive_s DRV_CLOSE_SLOW = 3'h4;
	localparam gsp_drive_s DRV_OPEN_SLOW  = 3'h6;
	localparam gsp_drive_s DRV_CLOSE_FAST = 3'h5;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ARM  = 8'h02,
		ST_ARMA = 8'h04,
		ST_ACL1 = 8'h08,
		ST_ACL2 = 8'h10,
		ST_AOPN = 8'h20,
		ST_AFCL = 8'h40,
		ST_MAN  = 8'h80
	} gsp_state_e;

	typedef struct packed {
		gsp_pins_s s1;
		gsp_pins_s s2;
	} gsp_sync_s;

	typedef struct packed {
		gsp_cnt_t cntS;
		gsp_cnt_t cntF;
		logic     slow;
		logic     fast;
	} gsp_blink_s;

	typedef struct packed {
		gsp_state_e st;
		gsp_idx_t   sel;
		gsp_cnt_t   holdCnt;
		gsp_cnt_t   btnCnt;
		gsp_cnt_t   idleCnt;
		logic       failFlag;
		logic       autoOk;
		logic       mixed;
		logic       busy;
		logic       leafOneGo;
		logic       leafTwoGo;
		logic       m1AtOpen;
		logic       m2AtOpen;
		gsp_ind_t   ind;
		gsp_motor_s mot;
		gsp_pins_s  prev;
		gsp_tbl_t   tbl;
	} gsp_learn_s;

	localparam gsp_learn_s LEARN_RST = '{st: ST_IDLE, default: '0};

	function automatic logic usesMotorTwo(input gsp_idx_t idx);
		return MOTOR2_MASK[idx];
	endfunction : usesMotorTwo

	function automatic logic isStopPos(input gsp_idx_t idx);
		return STOP_MASK[idx];
	endfunction : isStopPos

	function automatic gsp_ind_t indBit(input gsp_idx_t idx);
		return IND_ONE << idx;
	endfunction : indBit

	function automatic gsp_pos_t offsetPt(input gsp_pos_t cl, input gsp_pos_t op);
		return cl + ((op - cl) >> OFS_SHIFT);
	endfunction : offsetPt
endpackage : gsp_pkg

/* hdl/gsp_sync.sv */
// Two-stage synchroniser for the button and sensor pins
`timescale 1ns/10ps
module gsp_sync (
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic               clkEn,
	input  wire gsp_pkg::gsp_pins_s pinsAsync,
	output gsp_pkg::gsp_pins_s      pinsSync
);
	import gsp_pkg::*;
	gsp_sync_s r;
	gsp_sync_s n;

	// Stage one feeds only stage two
	always_comb begin
		n = r;
		n.s1 = pinsAsync;
		n.s2 = r.s1;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else if (clkEn) begin
			r <= n;
		end
	end

	assign pinsSync = r.s2;
endmodule : gsp_sync

/* hdl/gsp_blink.sv */
// Slow and fast flash timebase for the position indicators
`timescale 1ns/10ps
module gsp_blink #(
	parameter gsp_pkg::gsp_cnt_t SLOW_CYC = gsp_pkg::CYC_SLOW,
	parameter gsp_pkg::gsp_cnt_t FAST_CYC = gsp_pkg::CYC_FAST
) (
	input  wire logic clock,
	input  wire logic arst_n,
	input  wire logic clkEn,
	output logic      slowOn,
	output logic      fastOn
);
	import gsp_pkg::*;
	gsp_blink_s r;
	gsp_blink_s n;

	// Free-running half-period counters toggle each phase
	always_comb begin
		n = r;
		n.cntS = r.cntS + 1'b1;
		n.cntF = r.cntF + 1'b1;
		if (r.cntS >= SLOW_CYC - 1'b1) begin
			n.cntS = '0;
			n.slow = !r.slow;
		end
		if (r.cntF >= FAST_CYC - 1'b1) begin
			n.cntF = '0;
			n.fast = !r.fast;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else if (clkEn) begin
			r <= n;
		end
	end

	assign slowOn = r.slow;
	assign fastOn = r.fast;
endmodule : gsp_blink

/* sim/gsp_motor_model.sv */
// Behavioural pair of gearmotors with encoders and stall sensing at the stops
`timescale 1ns/10ps
module gsp_motor_model #(
	parameter gsp_pkg::gsp_pos_t CL_LIM = 16'h0064,
	parameter gsp_pkg::gsp_pos_t OP_LIM = 16'h012C,
	parameter gsp_pkg::gsp_pos_t START  = 16'h00C8
) (
	input  wire logic                clock,
	input  wire logic                arst_n,
	input  wire gsp_pkg::gsp_motor_s motorCmd,
	output gsp_pkg::gsp_pos_t        m1Pos,
	output gsp_pkg::gsp_pos_t        m2Pos,
	output logic                     m1Stop,
	output logic                     m2Stop
);
	import gsp_pkg::*;

	// Slow moves one count a cycle, fast four; a leaf never passes its stops
	function automatic gsp_pos_t nextPos(input gsp_pos_t pos, input gsp_drive_s drv);
		gsp_pos_t step;
		step = drv.fast ? 16'h0004 : 16'h0001;
		if (!drv.run) return pos;
		if (drv.dirOpen) return (pos >= OP_LIM - step) ? OP_LIM : pos + step;
		return (pos <= CL_LIM + step) ? CL_LIM : pos - step;
	endfunction : nextPos

	// Stall shows only while pushing on a stop, so an idle motor reports nothing
	function automatic logic stalled(input gsp_pos_t pos, input gsp_drive_s drv);
		return drv.run && (drv.dirOpen ? pos == OP_LIM : pos == CL_LIM);
	endfunction : stalled

	// Encoder counts follow the drive commands
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			m1Pos <= START;
			m2Pos <= START;
		end else begin
			m1Pos <= nextPos(m1Pos, motorCmd.m1);
			m2Pos <= nextPos(m2Pos, motorCmd.m2);
		end
	end

	// Stall sensing
	assign m1Stop = stalled(m1Pos, motorCmd.m1);
	assign m2Stop = stalled(m2Pos, motorCmd.m2);
endmodule : gsp_motor_model

/* sim/testbench.sv */
// Self-checking testbench for the stop position learning sequencer
`timescale 1ns/10ps
module testbench;
	import gsp_pkg::*;
	localparam gsp_pos_t CL  = 16'h0064;
	localparam gsp_pos_t OP  = 16'h012C;
	localparam gsp_pos_t MID = 16'h00C8;
	localparam gsp_pos_t OFS = CL + ((OP - CL) >> OFS_SHIFT);
	// Short counts keep every hold a few dozen cycles long
	localparam gsp_cnt_t SIM_MAN   = 28'h1E;
	localparam gsp_cnt_t SIM_AUTO  = 28'h32;
	localparam gsp_cnt_t SIM_LIT   = 28'h14;
	localparam gsp_cnt_t SIM_STORE = 28'h1E;
	localparam gsp_cnt_t SIM_IDLE  = 28'h64;
	localparam gsp_cnt_t SIM_BRIEF = 28'h5;
	localparam gsp_cnt_t SIM_SLOW  = 28'h4;
	localparam gsp_cnt_t SIM_FAST  = 28'h2;
	logic       clock;
	logic       arst_n;
	logic       clkEn;
	logic       devLearnPending;
	gsp_pins_s  btn;
	gsp_pins_s  pinsAll;
	gsp_pos_t   m1Pos;
	gsp_pos_t   m2Pos;
	logic       m1Stop;
	logic       m2Stop;
	gsp_ind_t   posInd;
	gsp_motor_s motorCmd;
	gsp_tbl_t   posTable;
	logic       leafOneGo;
	logic       leafTwoGo;
	logic       m1AtOpen;
	logic       m2AtOpen;
	logic       learnBusy;
	logic       learnFailed;
	logic       autoLearned;
	int         err_count;
	int         num_checks;
	gsp_pos_t   expTbl [8];
	gsp_pins_s  trip [4];

	// Buttons and trips from the bench, stall sensing from the motors
	assign pinsAll = {btn[6:2], m1Stop, m2Stop};

	gsp_learn #(
		.MAN_CYC(SIM_MAN), .AUTO_CYC(SIM_AUTO), .LIT_CYC(SIM_LIT), .STORE_CYC(SIM_STORE),
		.IDLE_CYC(SIM_IDLE), .BRIEF_CYC(SIM_BRIEF), .SLOW_CYC(SIM_SLOW), .FAST_CYC(SIM_FAST)
	) dut (
		.clock(clock), .arst_n(arst_n), .clkEn(clkEn), .pinsAsync(pinsAll),
		.m1Pos(m1Pos), .m2Pos(m2Pos), .devLearnPending(devLearnPending),
		.posInd(posInd), .motorCmd(motorCmd), .posTable(posTable),
		.leafOneGo(leafOneGo), .leafTwoGo(leafTwoGo), .m1AtOpen(m1AtOpen),
		.m2AtOpen(m2AtOpen), .learnBusy(learnBusy), .learnFailed(learnFailed),
		.autoLearned(autoLearned)
	);

	// Far side: the two gearmotors
	gsp_motor_model motors (
		.clock(clock), .arst_n(arst_n), .motorCmd(motorCmd),
		.m1Pos(m1Pos), .m2Pos(m2Pos), .m1Stop(m1Stop), .m2Stop(m2Stop)
	);

	// 10 MHz clock
	initial clock = 1'b0;
	always #50 clock = ~clock;

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	task automatic chkVec(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chkVec

	task automatic chkBit(input string name, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %b seen %b", name, exp, got);
		end
	endtask : chkBit

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	// Extra edge after release so the next press never lands in the same step
	task automatic hold(input gsp_pins_s pat, input int n);
		btn <= pat;
		cyc(n);
		btn <= '0;
		cyc(1);
	endtask : hold

	// Flashing lamps are judged by what lit over a window, since phase is free-running
	task automatic watchInd(input gsp_ind_t mask);
		gsp_ind_t seen;
		gsp_ind_t bad;
		seen = '0;
		bad = '0;
		repeat (24) begin
			@(posedge clock);
			seen = seen | posInd;
			bad = bad | (posInd & ~mask);
		end
		chkVec("indicators outside set", 16'h0000, 16'(bad));
		chkVec("indicators shown", 16'(mask), 16'(seen));
	endtask : watchInd

	task automatic waitMot(input gsp_motor_s exp, input int lim);
		int n;
		n = 0;
		while (motorCmd !== exp && n < lim) begin
			@(posedge clock);
			n++;
		end
		chkVec("motorCmd", 16'(exp), 16'(motorCmd));
		if (n >= lim) begin
			err_count++;
			summarize();
		end
	endtask : waitMot

	task automatic waitIdle(input int lim);
		int n;
		n = 0;
		while (learnBusy !== 1'b0 && n < lim) begin
			@(posedge clock);
			n++;
		end
		chkBit("learnBusy", 1'b0, learnBusy);
		if (n >= lim) begin
			err_count++;
			summarize();
		end
	endtask : waitIdle

	// Close plus confirm; released after the manual cue or held past the automatic cue
	task automatic startLearn(input logic isAuto);
		btn <= 7'h30;
		cyc(35);
		if (isAuto) begin
			cyc(20);
			watchInd(8'h0C);
		end
		btn <= '0;
		cyc(5);
		if (!isAuto) watchInd(8'h01);
	endtask : startLearn

	// Confirm held past the store time; lamp must turn steady while held
	task automatic storePos(input gsp_ind_t mask);
		btn <= 7'h10;
		cyc(26);
		repeat (10) begin
			@(posedge clock);
			chkVec("steady indicator", 16'(mask), 16'(posInd));
		end
		btn <= '0;
		cyc(5);
	endtask : storePos

	// Held open button drives the selected motor, release stops it
	task automatic driveOpen(input gsp_motor_s exp);
		btn <= 7'h40;
		cyc(15);
		chkVec("motorCmd held", 16'(exp), 16'(motorCmd));
		btn <= '0;
		cyc(4);
		chkVec("motorCmd released", 16'h0000, 16'(motorCmd));
	endtask : driveOpen

	task automatic testPending();
		hold(7'h30, 60);
		cyc(10);
		chkBit("learnBusy pending", 1'b0, learnBusy);
		watchInd(8'h03);
		devLearnPending <= 1'b0;
		$display("test pending done");
	endtask : testPending

	task automatic testManual();
		startLearn(1'b0);
		hold(7'h40, 2);
		cyc(5);
		watchInd(8'h02);
		hold(7'h20, 2);
		cyc(5);
		watchInd(8'h01);
		storePos(8'h01);
		chkVec("slot0", 16'(MID), 16'(posTable[0]));
		watchInd(8'h02);
		cyc(50);
		chkBit("learnBusy before idle", 1'b1, learnBusy);
		cyc(40);
		chkBit("learnBusy after idle", 1'b0, learnBusy);
		chkVec("slot0 kept", 16'(MID), 16'(posTable[0]));
		$display("test manual done");
	endtask : testManual

	task automatic testAuto();
		startLearn(1'b1);
		waitMot({DRV_CLOSE_SLOW, 3'h0}, 20);
		waitMot({3'h0, DRV_CLOSE_SLOW}, 300);
		waitMot({DRV_OPEN_SLOW, DRV_OPEN_SLOW}, 300);
		waitMot({DRV_CLOSE_FAST, DRV_CLOSE_FAST}, 400);
		waitIdle(200);
		chkBit("autoLearned", 1'b1, autoLearned);
		chkVec("posInd", 16'h0000, 16'(posInd));
		for (int k = 0; k < 8; k++) begin
			chkVec("posTable", 16'(expTbl[k]), 16'(posTable[k]));
		end
		chkBit("leafOneGo", 1'b0, leafOneGo);
		chkBit("leafTwoGo", 1'b1, leafTwoGo);
		chkBit("m1AtOpen", 1'b0, m1AtOpen);
		chkBit("m2AtOpen", 1'b0, m2AtOpen);
		$display("test automatic done");
	endtask : testAuto

	task automatic testMixed();
		startLearn(1'b0);
		driveOpen({DRV_OPEN_SLOW, 3'h0});
		storePos(8'h01);
		chkVec("slot0 locked", 16'(CL), 16'(posTable[0]));
		watchInd(8'h02);
		hold(7'h40, 2);
		cyc(5);
		watchInd(8'h04);
		driveOpen({3'h0, DRV_OPEN_SLOW});
		storePos(8'h04);
		chkVec("slot2", 16'(m2Pos), 16'(posTable[2]));
		watchInd(8'h08);
		waitIdle(150);
		$display("test mixed done");
	endtask : testMixed

	// Photocell and stop trips fail the run; open and close presses only halt it
	task automatic testAbort();
		for (int k = 0; k < 4; k++) begin
			startLearn(1'b1);
			waitMot({DRV_CLOSE_SLOW, 3'h0}, 20);
			hold(trip[k], 4);
			cyc(4);
			chkBit("learnBusy", 1'b0, learnBusy);
			chkVec("motorCmd", 16'h0000, 16'(motorCmd));
			chkBit("learnFailed", logic'(k < 2), learnFailed);
			if (k < 2) watchInd(8'h01);
		end
		$display("test abort done");
	endtask : testAbort

	// Enable low must freeze a start hold; a reset while idle forgets what was learned
	task automatic testFreeze();
		clkEn <= 1'b0;
		btn <= 7'h30;
		cyc(80);
		chkBit("learnBusy frozen", 1'b0, learnBusy);
		chkVec("posInd frozen", 16'h0000, 16'(posInd));
		btn <= '0;
		cyc(5);
		clkEn <= 1'b1;
		cyc(5);
		chkBit("learnBusy after freeze", 1'b0, learnBusy);
		arst_n <= 1'b0;
		cyc(2);
		arst_n <= 1'b1;
		cyc(2);
		chkBit("autoLearned after reset", 1'b0, autoLearned);
		chkVec("posTable slot6 after reset", 16'h0000, 16'(posTable[6]));
		chkVec("motorCmd after reset", 16'h0000, 16'(motorCmd));
		$display("test freeze done");
	endtask : testFreeze

	// Main sequence
	initial begin
		err_count = 0;
		num_checks = 0;
		expTbl = '{CL, CL, OFS, OP, OP, OFS, OP, OP};
		trip = '{7'h08, 7'h04, 7'h40, 7'h20};
		clkEn = 1'b1;
		devLearnPending = 1'b1;
		btn = '0;
		arst_n = 1'b0;
		cyc(3);
		arst_n <= 1'b1;
		cyc(1);
		chkVec("posTable slot0", 16'h0000, 16'(posTable[0]));
		chkVec("motorCmd", 16'h0000, 16'(motorCmd));
		chkBit("learnBusy", 1'b0, learnBusy);
		testPending();
		testManual();
		testAuto();
		testMixed();
		testAbort();
		testFreeze();
		summarize();
	end
endmodule : testbench
